// file: design/gtb_pkg.sv
// Constants and types of the global test and bus routing bank
package gtb_pkg;
    localparam int          GTB_NCH         = 4;
    localparam int          GTB_AW          = 18;
    // Register indices; byte address is four times the index
    localparam logic [15:0] GTB_IDX_TEST    = 16'hF800;
    localparam logic [15:0] GTB_IDX_ROUTE   = 16'hF801;
    localparam logic [15:0] GTB_IDX_STATUS  = 16'hF80E;
    localparam logic [15:0] GTB_IDX_MASK    = 16'hF80F;
    localparam logic [31:0] GTB_TEST_RST    = 32'h0000_0000;
    localparam logic [31:0] GTB_ROUTE_RST   = 32'h0000_0000;
    // Test control fields
    localparam int          GTB_TC_OVR_MSB  = 31;
    localparam int          GTB_TC_OVR_LSB  = 17;
    localparam int          GTB_TC_OVR_EN   = 16;
    localparam int          GTB_TC_SINE_MSB = 7;
    localparam int          GTB_TC_DECOR    = 3;
    localparam int          GTB_TC_PN23_EN  = 2;
    localparam int          GTB_TC_PN15_EN  = 1;
    localparam int          GTB_TC_SELFTEST = 0;
    // Bus routing fields
    localparam int          GTB_RT_PW_MSB   = 23;
    localparam int          GTB_RT_PW_LSB   = 20;
    localparam int          GTB_RT_DLY_MSB  = 19;
    localparam int          GTB_RT_DLY_LSB  = 17;
    localparam int          GTB_RT_AGC_SEL  = 16;
    localparam int          GTB_RT_CH3_MSB  = 15;
    localparam int          GTB_RT_CH3_LSB  = 14;
    localparam int          GTB_RT_CH2_SEL  = 13;
    localparam int          GTB_RT_CH1_SEL  = 12;
    localparam int          GTB_RT_BE_MSB   = 11;
    localparam logic [1:0]  GTB_CH3_SRC_MUX = 2'h0;
    localparam logic [1:0]  GTB_CH3_SRC_FIR = 2'h1;
    localparam logic [1:0]  GTB_CH3_SRC_CIC = 2'h2;
    localparam int          GTB_DLY_DEPTH   = 8;
    // Pseudo-noise generators
    localparam int          GTB_PN23_LEN    = 23;
    localparam int          GTB_PN23_TAP    = 17;
    localparam int          GTB_PN15_LEN    = 15;
    localparam int          GTB_PN15_TAP    = 13;
    localparam int          GTB_PN23_DECOR  = 10;
    localparam logic [22:0] GTB_PN23_SEED   = 23'h00_0001;
    localparam logic [14:0] GTB_PN15_SEED   = 15'h0001;
    // Interrupt status events
    localparam int          GTB_NEVT        = 2;
    localparam int          GTB_EV_PULSE    = 0;
    localparam int          GTB_EV_DROP     = 1;
    localparam logic [1:0]  GTB_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  GTB_RESP_SLVERR = 2'h2;

    // Pin bundle; field order matches test bits 31 down to 17
    typedef struct packed {
        logic       irq;
        logic       sync_out;
        logic       sclk;
        logic [0:3] sync_ch;
        logic [0:3] sd_pri;
        logic [0:3] sd_sec;
    } gtb_pins_t;
endpackage : gtb_pkg

// file: design/gtb_global_bank.sv
// Global test control and bus routing bank with AXI4-Lite access
`timescale 1ns/10ps
module gtb_global_bank
    import gtb_pkg::*;
#(
    parameter int DW = 24,
    parameter int GW = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,

    input  wire logic              s_axi_awvalid,
    output      logic              s_axi_awready,
    input  wire logic [GTB_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output      logic              s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output      logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output      logic [1:0]        s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output      logic              s_axi_arready,
    input  wire logic [GTB_AW-1:0] s_axi_araddr,
    output      logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output      logic [31:0]       s_axi_rdata,
    output      logic [1:0]        s_axi_rresp,

    output      logic              irq,
    input  wire logic              chan_irq_evt,
    input  wire gtb_pins_t         pins_norm,
    input  wire logic [0:3]        sine_msb,
    input  wire logic              sclk_div_sel,
    output      gtb_pins_t         pins_out,
    output      logic              test_mode,
    output      logic              pn_i,
    output      logic              pn_q,

    input  wire logic              ch1_valid_in,
    output      logic              ch1_output_valid_delay,

    input  wire logic [GW-1:0]     agc_loop  [GTB_NCH],
    output      logic [GW-1:0]     ch0_ext_gain,
    input  wire logic [DW-1:0]     cic_out   [GTB_NCH],
    input  wire logic [DW-1:0]     fir_out   [GTB_NCH],
    output      logic [DW-1:0]     fir_ext_in [GTB_NCH],
    output      logic [DW-1:0]     backend_in [GTB_NCH]
);

    logic [31:0]          test_q;
    logic [31:0]          route_q;
    logic [GTB_NEVT-1:0]  status_q;
    logic [GTB_NEVT-1:0]  mask_q;

    logic                 aw_have_q;
    logic                 w_have_q;
    logic [GTB_AW-1:0]    awaddr_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;

    logic                 wr_do;
    logic [15:0]          wr_idx;
    logic [15:0]          rd_idx;
    logic [31:0]          wmask;

    logic [GTB_NEVT-1:0]  evt_set;
    logic [3:0]           pulse_cnt_q;
    logic [3:0]           pulse_width;

    logic [GTB_PN23_LEN-1:0] pn23_q;
    logic [GTB_PN15_LEN-1:0] pn15_q;
    logic                 pn_mix;

    logic [GTB_DLY_DEPTH-1:0] vdly_q;
    logic [2:0]           vdly_sel;

    logic                 ovr_active;
    gtb_pins_t            pins_d;
    gtb_pins_t            ovr_val;

    logic [DW-1:0]        chain_sel [GTB_NCH];
    logic [DW-1:0]        be_sel    [GTB_NCH];

    // AXI4-Lite write path: address and data taken in either order
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign wr_do         = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_idx        = awaddr_q[GTB_AW-1:2];

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{wstrb_q[b]}};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (wr_do) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (wr_do) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= GTB_RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            if (wr_idx == GTB_IDX_TEST || wr_idx == GTB_IDX_ROUTE ||
                wr_idx == GTB_IDX_STATUS || wr_idx == GTB_IDX_MASK) begin
                s_axi_bresp <= GTB_RESP_OKAY;
            end else begin
                s_axi_bresp <= GTB_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Unused test and route fields are stored as written; zeroing them is software's job
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            test_q  <= GTB_TEST_RST;
            route_q <= GTB_ROUTE_RST;
            mask_q  <= '0;
        end else if (wr_do) begin
            if (wr_idx == GTB_IDX_TEST) begin
                test_q <= (test_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_idx == GTB_IDX_ROUTE) begin
                route_q <= (route_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_idx == GTB_IDX_MASK) begin
                mask_q <= (mask_q & ~wmask[GTB_NEVT-1:0]) |
                          (wdata_q[GTB_NEVT-1:0] & wmask[GTB_NEVT-1:0]);
            end
        end
    end

    // Read path: one cycle from address to data
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx        = s_axi_araddr[GTB_AW-1:2];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= GTB_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= GTB_RESP_OKAY;
            unique case (rd_idx)
                GTB_IDX_TEST:   s_axi_rdata <= test_q;
                GTB_IDX_ROUTE:  s_axi_rdata <= route_q;
                GTB_IDX_STATUS: s_axi_rdata <= {{(32-GTB_NEVT){1'b0}},
                                                status_q};
                GTB_IDX_MASK:   s_axi_rdata <= {{(32-GTB_NEVT){1'b0}},
                                                mask_q};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= GTB_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Sticky status: a new event beats a same-cycle clear
    always_comb begin
        evt_set = '0;
        evt_set[GTB_EV_PULSE] = chan_irq_evt && (pulse_cnt_q == 4'h0) &&
                                (pulse_width != 4'h0);
        evt_set[GTB_EV_DROP]  = chan_irq_evt && (pulse_cnt_q != 4'h0);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            status_q <= '0;
        end else if (wr_do && wr_idx == GTB_IDX_STATUS && wstrb_q[0]) begin
            status_q <= (status_q & ~wdata_q[GTB_NEVT-1:0]) | evt_set;
        end else begin
            status_q <= status_q | evt_set;
        end
    end

    assign irq = |(status_q & mask_q);

    // Interrupt pin pulse; a width of zero issues no pulse
    assign pulse_width = route_q[GTB_RT_PW_MSB:GTB_RT_PW_LSB];

    // Only rst clears it, so channel resets never cut a pulse short
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pulse_cnt_q <= 4'h0;
        end else if (pulse_cnt_q != 4'h0) begin
            pulse_cnt_q <= pulse_cnt_q - 4'h1;
        end else if (chan_irq_evt) begin
            pulse_cnt_q <= pulse_width;
        end
    end

    // Pseudo-noise generators; a disabled one holds and drives zero into the mix, but the decorrelation bit still reads pn23_q
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pn23_q <= GTB_PN23_SEED;
        end else if (test_q[GTB_TC_PN23_EN]) begin
            pn23_q <= {pn23_q[GTB_PN23_LEN-2:0],
                       pn23_q[GTB_PN23_LEN-1] ^ pn23_q[GTB_PN23_TAP]};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pn15_q <= GTB_PN15_SEED;
        end else if (test_q[GTB_TC_PN15_EN]) begin
            pn15_q <= {pn15_q[GTB_PN15_LEN-2:0],
                       pn15_q[GTB_PN15_LEN-1] ^ pn15_q[GTB_PN15_TAP]};
        end
    end

    assign pn_mix = (test_q[GTB_TC_PN23_EN] & pn23_q[GTB_PN23_LEN-1]) ^
                    (test_q[GTB_TC_PN15_EN] &
                     pn15_q[GTB_PN15_LEN-1]);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pn_i <= 1'b0;
            pn_q <= 1'b0;
        end else begin
            pn_q <= pn_mix;
            pn_i <= pn_mix ^ (test_q[GTB_TC_DECOR] &
                              pn23_q[GTB_PN23_DECOR]);
        end
    end

    // Self-test mode flag for the rest of the device
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            test_mode <= 1'b0;
        end else begin
            test_mode <= test_q[GTB_TC_SELFTEST];
        end
    end

    // Channel 1 output-valid delay, taps 1 to 8 cycles
    assign vdly_sel = route_q[GTB_RT_DLY_MSB:GTB_RT_DLY_LSB];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vdly_q <= '0;
        end else begin
            vdly_q <= {vdly_q[GTB_DLY_DEPTH-2:0], ch1_valid_in};
        end
    end

    assign ch1_output_valid_delay = vdly_q[vdly_sel];

    // Pin drive: normal functions, sine probe, or board-test override
    assign ovr_active = test_q[GTB_TC_OVR_EN] && test_q[GTB_TC_SELFTEST];
    assign ovr_val    = gtb_pins_t'(
        test_q[GTB_TC_OVR_MSB:GTB_TC_OVR_LSB]);

    always_comb begin
        pins_d     = pins_norm;
        pins_d.irq = pins_norm.irq | (pulse_cnt_q != 4'h0);
        for (int c = 0; c < GTB_NCH; c++) begin
            if (test_q[GTB_TC_SINE_MSB - c]) begin
                pins_d.sd_sec[c] = sine_msb[c];
            end
        end
        if (ovr_active) begin
            pins_d = ovr_val;
            // Undivided serial clock cannot be forced, it stays live
            if (!sclk_div_sel) begin
                pins_d.sclk = pins_norm.sclk;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pins_out <= '0;
        end else begin
            pins_out <= pins_d;
        end
    end

    // Cascade chain source selects, built up channel by channel
    always_comb begin
        chain_sel[0] = cic_out[0];
        chain_sel[1] = route_q[GTB_RT_CH1_SEL] ? fir_out[0]
                                               : cic_out[0];
        chain_sel[2] = route_q[GTB_RT_CH2_SEL] ? fir_out[1]
                                               : chain_sel[1];
        unique case (route_q[GTB_RT_CH3_MSB:GTB_RT_CH3_LSB])
            GTB_CH3_SRC_MUX: chain_sel[3] = chain_sel[2];
            GTB_CH3_SRC_FIR: chain_sel[3] = fir_out[2];
            GTB_CH3_SRC_CIC: chain_sel[3] = cic_out[2];
            default:         chain_sel[3] = chain_sel[2];
        endcase
    end

    always_comb begin
        be_sel[0] = route_q[GTB_RT_BE_MSB] ? cic_out[1]
            : cic_out[0];
        for (int c = 1; c < GTB_NCH; c++) begin
            be_sel[c] = route_q[GTB_RT_BE_MSB - c] ? chain_sel[c]
                                                   : cic_out[c];
        end
    end

    // Muxes only steer samples; no stored data is reset on a switch
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < GTB_NCH; c++) begin
                fir_ext_in[c] <= '0;
                backend_in[c] <= '0;
            end
            ch0_ext_gain <= '0;
        end else begin
            fir_ext_in[0] <= '0;
            for (int c = 1; c < GTB_NCH; c++) begin
                fir_ext_in[c] <= chain_sel[c];
            end
            for (int c = 0; c < GTB_NCH; c++) begin
                backend_in[c] <= be_sel[c];
            end
            ch0_ext_gain <= route_q[GTB_RT_AGC_SEL] ? agc_loop[1]
                                                    : agc_loop[3];
        end
    end

endmodule : gtb_global_bank

// file: testbench/gtb_global_bank_properties.sv
// Assertion checker for the global test and bus routing bank
`timescale 1ns/10ps
module gtb_checker
    import gtb_pkg::*;
#(
    parameter int DW = 24,
    parameter int GW = 16
) (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [GTB_AW-1:0] s_axi_awaddr,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              sclk_div_sel,
    input wire gtb_pins_t         pins_out,
    input wire logic              test_mode,
    input wire logic              pn_i,
    input wire logic              pn_q,
    input wire logic [GW-1:0]     agc_loop [GTB_NCH],
    input wire logic [GW-1:0]     ch0_ext_gain,
    input wire logic [DW-1:0]     cic_out [GTB_NCH],
    input wire logic [DW-1:0]     fir_out [GTB_NCH],
    input wire logic [DW-1:0]     fir_ext_in [GTB_NCH],
    input wire logic [DW-1:0]     backend_in [GTB_NCH]
);
    logic [31:0] test_q;
    logic [31:0] route_q;
    logic [3:0]  quiet_q;
    logic [3:0]  high_q;
    logic        wr_go;
    logic        settled;
    // Shadow trusts whole-word writes with address and data together
    assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                   && s_axi_wready && s_axi_wstrb == 4'hF;
    // Routing outputs lag a write by two cycles, so wait well past them
    assign settled = quiet_q == 4'hF;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            test_q  <= GTB_TEST_RST;
            route_q <= GTB_ROUTE_RST;
            quiet_q <= 4'h0;
        end else begin
            if (wr_go && s_axi_awaddr == {GTB_IDX_TEST, 2'h0})
                test_q <= s_axi_wdata;
            if (wr_go && s_axi_awaddr == {GTB_IDX_ROUTE, 2'h0})
                route_q <= s_axi_wdata;
            if (wr_go)
                quiet_q <= 4'h0;
            else if (quiet_q != 4'hF)
                quiet_q <= quiet_q + 4'h1;
        end
    end

    // Length of the current high run on the interrupt pin
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            high_q <= 4'h0;
        else
            high_q <= pins_out.irq ? high_q + 4'h1 : 4'h0;
    end

    sequence s_quiet_normal;
        settled && !test_q[GTB_TC_OVR_EN];
    endsequence
    sequence s_pulse_end;
        $fell(pins_out.irq) ##0 s_quiet_normal;
    endsequence

    property p_test_mode;
        settled |-> test_mode == test_q[GTB_TC_SELFTEST];
    endproperty
    a_test_mode: assert property (p_test_mode)
        else $error("test mode output differs from register");
    property p_override;
        settled && test_q[GTB_TC_OVR_EN] && test_q[GTB_TC_SELFTEST]
        && sclk_div_sel && $past(sclk_div_sel)
        |-> pins_out == test_q[GTB_TC_OVR_MSB:GTB_TC_OVR_LSB];
    endproperty
    a_override: assert property (p_override)
        else $error("pins do not show the test pattern");
    property p_pn_same;
        !test_q[GTB_TC_DECOR] && !$past(test_q[GTB_TC_DECOR])
        && !$past(test_q[GTB_TC_DECOR], 2) |-> pn_i == pn_q;
    endproperty
    a_pn_same: assert property (p_pn_same)
        else $error("dither differs between paths");
    property p_gain;
        settled |-> ch0_ext_gain ==
            (route_q[GTB_RT_AGC_SEL] ? agc_loop[1] : agc_loop[3]);
    endproperty
    a_gain: assert property (p_gain)
        else $error("channel 0 gain source wrong");
    property p_ch1_src;
        settled |-> fir_ext_in[1] ==
            (route_q[GTB_RT_CH1_SEL] ? fir_out[0] : cic_out[0]);
    endproperty
    a_ch1_src: assert property (p_ch1_src)
        else $error("channel 1 chain source wrong");
    property p_ch2_src;
        settled |-> fir_ext_in[2] ==
            (route_q[GTB_RT_CH2_SEL] ? fir_out[1] : fir_ext_in[1]);
    endproperty
    a_ch2_src: assert property (p_ch2_src)
        else $error("channel 2 chain source wrong");
    property p_backend0;
        settled |-> backend_in[0] ==
            (route_q[GTB_RT_BE_MSB] ? cic_out[1] : cic_out[0]);
    endproperty
    a_backend0: assert property (p_backend0)
        else $error("channel 0 backend source wrong");
    property p_irq_width;
        s_pulse_end |-> high_q == route_q[GTB_RT_PW_MSB:GTB_RT_PW_LSB];
    endproperty
    a_irq_width: assert property (p_irq_width)
        else $error("interrupt pulse width wrong");
endmodule : gtb_checker

bind gtb_global_bank gtb_checker #(.DW(DW), .GW(GW)) u_chk (.*);

// file: testbench/tb_global_test_and_bus_routing.sv
// Self-checking bench of the global test and bus routing bank
`timescale 1ns/10ps
module tb_global_test_and_bus_routing
    import gtb_pkg::*;
;
    typedef struct packed {
        logic [31:0] rt;
        logic [15:0] gain;
    } gtb_row_t;
    localparam gtb_row_t ROWS [5] = '{'{32'h0000_0000, 16'hA003},
        '{32'h0001_5F00, 16'hA001}, '{32'h0000_A000, 16'hA003},
        '{32'h0001_3A00, 16'hA001}, '{32'h0000_E500, 16'hA003}};
    logic [31:0]       pn_cfg [5] = '{32'h6, 32'h2, 32'h4, 32'hE, 32'hC};
    logic [3:0]        pw [3] = '{4'h1, 4'h3, 4'hF};
    logic              clk_sys = 1'b0;
    logic              rst = 1'b1;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic              s_axi_rready, irq, chan_irq_evt, sclk_div_sel;
    logic              test_mode, pn_i, pn_q;
    logic              ch1_valid_in, ch1_output_valid_delay;
    logic [GTB_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [0:3]        sine_msb;
    gtb_pins_t         pins_norm, pins_out;
    logic [15:0]       agc_loop [GTB_NCH];
    logic [15:0]       ch0_ext_gain;
    logic [23:0]       cic_out [GTB_NCH], fir_out [GTB_NCH];
    logic [23:0]       fir_ext_in [GTB_NCH], backend_in [GTB_NCH];
    int                fails = 0;
    int                cmp_count = 0;
    int                n, k;

    gtb_global_bank u_dut (.*);

    always #2.5 clk_sys = ~clk_sys;

    task automatic summarize;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // A wait that used up its bound ends the run at once
    task automatic guard(input int cnt);
        if (cnt >= 100) begin
            fails++;
            summarize();
        end
    endtask : guard

    task automatic tick(input int cnt);
        repeat (cnt) @(posedge clk_sys);
    endtask : tick

    task automatic wr(input logic [15:0] idx, input logic [31:0] d,
                      input logic [1:0] er);
        int  c;
        logic a, w;
        a = 1'b1;
        w = 1'b1;
        c = 0;
        s_axi_awaddr  <= {idx, 2'h0};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (c < 100) begin
            @(posedge clk_sys);
            c++;
            if (s_axi_awready)
                a = 1'b0;
            if (s_axi_wready)
                w = 1'b0;
            s_axi_awvalid <= a;
            s_axi_wvalid  <= w;
            if (s_axi_bvalid)
                break;
        end
        s_axi_bready <= 1'b0;
        guard(c);
        chk("bresp", 32'(s_axi_bresp), 32'(er));
    endtask : wr

    task automatic rd(input logic [15:0] idx, input logic [31:0] e,
                      input logic [1:0] er);
        int c;
        c = 0;
        s_axi_araddr  <= {idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (c < 100) begin
            @(posedge clk_sys);
            c++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        s_axi_rready <= 1'b0;
        guard(c);
        chk("rdata", s_axi_rdata, e);
        chk("rresp", 32'(s_axi_rresp), 32'(er));
    endtask : rd

    task automatic chk_route(input gtb_row_t row);
        logic [23:0] f1, f2, f3;
        logic [31:0] r;
        r  = row.rt;
        f1 = r[12] ? fir_out[0] : cic_out[0];
        f2 = r[13] ? fir_out[1] : f1;
        f3 = r[15:14] == 2'h1 ? fir_out[2] :
             r[15:14] == 2'h2 ? cic_out[2] : f2;
        chk("ext1", 32'(fir_ext_in[1]), 32'(f1));
        chk("ext2", 32'(fir_ext_in[2]), 32'(f2));
        chk("ext3", 32'(fir_ext_in[3]), 32'(f3));
        chk("be0", 32'(backend_in[0]),
            32'(r[11] ? cic_out[1] : cic_out[0]));
        chk("be1", 32'(backend_in[1]),
            32'(r[10] ? f1 : cic_out[1]));
        chk("be2", 32'(backend_in[2]), 32'(r[9] ? f2 : cic_out[2]));
        chk("be3", 32'(backend_in[3]), 32'(r[8] ? f3 : cic_out[3]));
        chk("gain", 32'(ch0_ext_gain), 32'(row.gain));
    endtask : chk_route

    task automatic fire;
        @(posedge clk_sys);
        chan_irq_evt <= 1'b1;
        @(posedge clk_sys);
        chan_irq_evt <= 1'b0;
    endtask : fire

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
        {s_axi_arvalid, s_axi_rready, chan_irq_evt} <= 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
        s_axi_wstrb  <= 4'hF;
        sclk_div_sel <= 1'b1;
        ch1_valid_in <= 1'b0;
        sine_msb     <= 4'hF;
        pins_norm    <= 15'h0234;
        for (int i = 0; i < GTB_NCH; i++) begin
            cic_out[i]  <= 24'hC00000 + 24'(i);
            fir_out[i]  <= 24'hF00000 + 24'(i);
            agc_loop[i] <= 16'hA000 + 16'(i);
        end
        tick(6);
        rst <= 1'b0;
        rd(GTB_IDX_TEST, GTB_TEST_RST, GTB_RESP_OKAY);
        tick(1);
        rd(GTB_IDX_ROUTE, GTB_ROUTE_RST, GTB_RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            wr(GTB_IDX_ROUTE, ROWS[i].rt, GTB_RESP_OKAY);
            tick(16);
            rd(GTB_IDX_ROUTE, ROWS[i].rt, GTB_RESP_OKAY);
            chk_route(ROWS[i]);
        end
        // Unmapped word: refused, nothing stored
        wr(16'hF802, 32'hFFFF_FFFF, GTB_RESP_SLVERR);
        rd(16'hF802, 32'h0, GTB_RESP_SLVERR);
        wr(GTB_IDX_TEST, 32'hAAAB_0001, GTB_RESP_OKAY);
        tick(16);
        chk("pins_ovr", 32'(pins_out), 32'h5555);
        chk("tmode", 32'(test_mode), 32'h1);
        sclk_div_sel <= 1'b0;
        tick(4);
        chk("pins_sclk", 32'(pins_out), 32'h4555);
        wr(GTB_IDX_TEST, 32'hAAAB_0000, GTB_RESP_OKAY);
        tick(16);
        chk("pins_norm", 32'(pins_out), 32'h0234);
        chk("tmode", 32'(test_mode), 32'h0);
        wr(GTB_IDX_TEST, 32'h0000_00A0, GTB_RESP_OKAY);
        tick(16);
        chk("pins_sine", 32'(pins_out), 32'h023E);
        for (int i = 0; i < 5; i++) begin
            wr(GTB_IDX_TEST, pn_cfg[i], GTB_RESP_OKAY);
            tick(8);
            n = 0;
            k = 0;
            repeat (200) begin
                @(posedge clk_sys);
                n += pn_q;
                k += pn_i ^ pn_q;
            end
            chk("pn_run", 32'(n > 0 && n < 200), 32'h1);
            chk("pn_decor", 32'(k > 0), 32'(pn_cfg[i][3]));
        end
        for (int i = 0; i < 3; i++) begin
            wr(GTB_IDX_ROUTE, {8'h00, pw[i], 20'h0}, GTB_RESP_OKAY);
            tick(16);
            fire();
            n = 0;
            repeat (24) begin
                @(posedge clk_sys);
                n += pins_out.irq;
            end
            chk("pulse", n, 32'(pw[i]));
        end
        // Second event while the pin is busy is dropped and flagged
        fire();
        tick(5);
        fire();
        tick(24);
        rd(GTB_IDX_STATUS, 32'h3, GTB_RESP_OKAY);
        chk("irq_masked", 32'(irq), 32'h0);
        wr(GTB_IDX_MASK, 32'h1, GTB_RESP_OKAY);
        tick(1);
        chk("irq_on", 32'(irq), 32'h1);
        wr(GTB_IDX_STATUS, 32'h1, GTB_RESP_OKAY);
        rd(GTB_IDX_STATUS, 32'h2, GTB_RESP_OKAY);
        chk("irq_clr", 32'(irq), 32'h0);
        for (int f = 0; f < 8; f += 7) begin
            wr(GTB_IDX_ROUTE, 32'(f) << 17, GTB_RESP_OKAY);
            tick(16);
            ch1_valid_in <= 1'b1;
            k = 0;
            do begin
                @(posedge clk_sys);
                ch1_valid_in <= 1'b0;
                k++;
                #1;
            end while (!ch1_output_valid_delay && k < 100);
            guard(k);
            chk("valid_dly", k, 32'(f + 1));
        end
        // Hardware reset in mid-pulse must cut the pulse short
        wr(GTB_IDX_ROUTE, 32'h00F0_0000, GTB_RESP_OKAY);
        tick(16);
        fire();
        tick(4);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        n = 0;
        repeat (20) begin
            @(posedge clk_sys);
            n += pins_out.irq;
        end
        chk("rst_pulse", n, 32'h0);
        summarize();
    end
endmodule : tb_global_test_and_bus_routing
